// >>> rtl/ppd_pad_decode.sv
`timescale 1ns/1ps
`default_nettype none

// Decodes per-pin mode fields into pad controls (combinational)
module ppd_pad_decode #(
  parameter int PINS = 8
) (
  input  wire logic [2*PINS-1:0] modeFields,
  input  wire logic [PINS-1:0]   portLatch,
  output var  ppd_pkg::ppd_pad_t padCtl
);

  // ----------------------------------------
  // Elaboration check
  // ----------------------------------------
  if (PINS != ppd_pkg::PORT_WIDTH) begin : gPinsCheck
    $error("ppd_pad_decode supports only eight-pin ports");
  end

  // ----------------------------------------
  // Per-pin decode
  // ----------------------------------------
  always_comb begin
    padCtl = '0;
    for (int i = 0; i < PINS; i++) begin
      case (ppd_pkg::ppd_mode_t'(modeFields[2*i +: 2]))
        ppd_pkg::PPD_MODE_PULLUP: begin            // R5
          padCtl.pullUpEnable[i] = portLatch[i];
          padCtl.outEnable[i]    = ~portLatch[i];
          padCtl.dataOut[i]      = portLatch[i];
        end
        ppd_pkg::PPD_MODE_PUSHPULL: begin          // R6
          padCtl.outEnable[i]    = 1'b1;
          padCtl.dataOut[i]      = portLatch[i];
        end
        ppd_pkg::PPD_MODE_OPENDRAIN: begin         // R7
          padCtl.outEnable[i]    = ~portLatch[i];
          padCtl.dataOut[i]      = 1'b0;
        end
        default: begin                             // R8
          padCtl.outEnable[i]    = 1'b0;
          padCtl.dataOut[i]      = 1'b0;
        end
      endcase
    end
  end

endmodule // ppd_pad_decode
`default_nettype wire

// >>> rtl/ppd_pin_sync.sv
`timescale 1ns/1ps
`default_nettype none

// Two-flop synchroniser for a bank of pin levels
module ppd_pin_sync #(
  parameter int WIDTH = 8
) (
  input  wire logic             clock,
  input  wire logic             reset,
  input  wire logic [WIDTH-1:0] pinIn,
  output var  logic [WIDTH-1:0] pinSync
);

  typedef struct packed {
    logic [WIDTH-1:0] stage1;                           // First flop, read only by second
    logic [WIDTH-1:0] stage2;                           // Safe sampled level
  } ppd_sync_state_t;

  ppd_sync_state_t state_reg;                           // Registered state
  ppd_sync_state_t state_next;                          // Next state

  // ----------------------------------------
  // Next state
  // ----------------------------------------
  always_comb begin
    state_next        = state_reg;
    state_next.stage1 = pinIn;
    state_next.stage2 = state_reg.stage1;
  end

  // ----------------------------------------
  // Registers
  // ----------------------------------------
  always_ff @(posedge clock) begin
    if (reset) begin
      state_reg <= '0;
    end else begin
      state_reg <= state_next;
    end
  end

  assign pinSync = state_reg.stage2;

endmodule // ppd_pin_sync
`default_nettype wire

// >>> rtl/ppd_pkg.sv
package ppd_pkg;

  // ----------------------------------------
  // Register map (special-function addresses)
  // ----------------------------------------
  localparam logic [7:0] ADDR_PORT0_MODE_LOW  = 8'h_AC; // First port pins 3..0
  localparam logic [7:0] ADDR_PORT0_MODE_HIGH = 8'h_AD; // First port pins 7..4
  localparam logic [7:0] ADDR_PORT1_MODE_LOW  = 8'h_AE; // Second port pins 3..0
  localparam logic [7:0] ADDR_PORT1_MODE_HIGH = 8'h_AF; // Second port pins 7..4
  localparam logic [7:0] RESET_MODE_REG       = 8'h_00; // All pins quasi-bidirectional

  // ----------------------------------------
  // Field layout
  // ----------------------------------------
  localparam int PINS_PER_REG = 4;                      // Two-bit fields per register
  localparam int MODE_WIDTH   = 2;                      // Bits per pin field
  localparam int PORT_WIDTH   = 8;                      // Pins per port

  // ----------------------------------------
  // Pad modes
  // ----------------------------------------
  typedef enum logic [1:0] {
    PPD_MODE_PULLUP    = 2'h_0,                         // Quasi-bidirectional
    PPD_MODE_PUSHPULL  = 2'h_1,                         // Driven high and low
    PPD_MODE_OPENDRAIN = 2'h_2,                         // Driven low only
    PPD_MODE_INPUT     = 2'h_3                          // No drive
  } ppd_mode_t;

  // ----------------------------------------
  // Carriers
  // ----------------------------------------
  typedef struct packed {
    logic       write;                                  // Write strobe
    logic       read;                                   // Read strobe
    logic [7:0] addr;                                   // Register address
    logic [7:0] wdata;                                  // Write data
  } ppd_sfr_req_t;

  typedef struct packed {
    logic [PORT_WIDTH-1:0] dataOut;                     // Pin output level
    logic [PORT_WIDTH-1:0] outEnable;                   // High while driving
    logic [PORT_WIDTH-1:0] pullUpEnable;                // Weak pull-up on
  } ppd_pad_t;

endpackage : ppd_pkg

// >>> rtl/ppd_port_config.sv
// Operation
// R1 - First port low register at ACh
// R2 - First port high register at ADh
// R3 - Second port low register at AEh
// R4 - Second port high register at AFh
// R5 - Mode 0: quasi-bidirectional with pull-up
// R6 - Mode 1: push-pull output
// R7 - Mode 2: open-drain, low only
// R8 - Mode 3: input only, no drive
// R9 - External bus overrides first port modes
// R10 - Reads return sampled pin level always
// R11 - Mode write reaches pads next cycle; code drives pads two cycles after the write
`timescale 1ns/1ps
`default_nettype none

module ppd_port_config #(
  parameter int PORT_WIDTH = 8
) (
  input  wire logic                    clock,
  input  wire logic                    reset,
  input  wire ppd_pkg::ppd_sfr_req_t   sfrReq,
  output var  logic [7:0]              sfrRdata,
  output var  logic                    sfrRvalid,
  input  wire logic [PORT_WIDTH-1:0]   port0Latch,
  input  wire logic [PORT_WIDTH-1:0]   port1Latch,
  input  wire logic                    externalAccessPin,
  input  wire logic                    generalPort0Enable,
  input  wire logic [PORT_WIDTH-1:0]   port0BusOut,
  input  wire logic                    port0BusDrive,
  input  wire logic [PORT_WIDTH-1:0]   port0PinIn,
  input  wire logic [PORT_WIDTH-1:0]   port1PinIn,
  output var  logic [PORT_WIDTH-1:0]   port0PinLevel,
  output var  logic [PORT_WIDTH-1:0]   port1PinLevel,
  output var  ppd_pkg::ppd_pad_t       port0Pad,
  output var  ppd_pkg::ppd_pad_t       port1Pad
);

  // ----------------------------------------
  // Elaboration check
  // ----------------------------------------
  if (PORT_WIDTH != ppd_pkg::PORT_WIDTH) begin : gWidthCheck
    $error("ppd_port_config supports only eight-pin ports");
  end

  // ----------------------------------------
  // State
  // ----------------------------------------
  typedef struct packed {
    logic [7:0]        port0ModeLow;                    // First port pins 3..0
    logic [7:0]        port0ModeHigh;                   // First port pins 7..4
    logic [7:0]        port1ModeLow;                    // Second port pins 3..0
    logic [7:0]        port1ModeHigh;                   // Second port pins 7..4
    logic [7:0]        rdata;                           // Read data
    logic              rvalid;                          // Read answer strobe
    logic              extBusSel;                       // First port serves memory bus
    logic [7:0]        p0Level;                         // Pin level seen by core
    logic [7:0]        p1Level;                         // Pin level seen by core
    ppd_pkg::ppd_pad_t pad0;                            // First port pad controls
    ppd_pkg::ppd_pad_t pad1;                            // Second port pad controls
  } ppd_cfg_state_t;

  ppd_cfg_state_t    state_reg;                         // Registered state
  ppd_cfg_state_t    state_next;                        // Next state
  logic [7:0]        p0Sync;                            // Synchronised first port pins
  logic [7:0]        p1Sync;                            // Synchronised second port pins
  ppd_pkg::ppd_pad_t pad0Dec;                           // Decoded first port pads
  ppd_pkg::ppd_pad_t pad1Dec;                           // Decoded second port pads
  logic              extAccessSync;                     // Synchronised external-access pin

  // ----------------------------------------
  // Address match helper
  // ----------------------------------------
  function automatic logic hit(input logic [7:0] a, input logic [7:0] b);
    hit = (a == b);
  endfunction

  // ----------------------------------------
  // Pin synchronisers
  // ----------------------------------------
  ppd_pin_sync #(.WIDTH(9)) uSync0 (
    .clock   (clock),
    .reset   (reset),
    .pinIn   ({externalAccessPin, port0PinIn}),
    .pinSync ({extAccessSync, p0Sync})
  );

  ppd_pin_sync #(.WIDTH(8)) uSync1 (
    .clock   (clock),
    .reset   (reset),
    .pinIn   (port1PinIn),
    .pinSync (p1Sync)
  );

  // ----------------------------------------
  // Mode decoders
  // ----------------------------------------
  ppd_pad_decode #(.PINS(8)) uDec0 (
    .modeFields ({state_reg.port0ModeHigh, state_reg.port0ModeLow}),
    .portLatch  (port0Latch),
    .padCtl     (pad0Dec)
  );

  ppd_pad_decode #(.PINS(8)) uDec1 (
    .modeFields ({state_reg.port1ModeHigh, state_reg.port1ModeLow}),
    .portLatch  (port1Latch),
    .padCtl     (pad1Dec)
  );

  // ----------------------------------------
  // Next state
  // ----------------------------------------
  always_comb begin
    state_next        = state_reg;
    state_next.rvalid = 1'b0;
    // Register writes
    if (sfrReq.write) begin
      if (hit(sfrReq.addr, ppd_pkg::ADDR_PORT0_MODE_LOW)) begin
        state_next.port0ModeLow = sfrReq.wdata;        // R1
      end
      if (hit(sfrReq.addr, ppd_pkg::ADDR_PORT0_MODE_HIGH)) begin
        state_next.port0ModeHigh = sfrReq.wdata;       // R2
      end
      if (hit(sfrReq.addr, ppd_pkg::ADDR_PORT1_MODE_LOW)) begin
        state_next.port1ModeLow = sfrReq.wdata;        // R3
      end
      if (hit(sfrReq.addr, ppd_pkg::ADDR_PORT1_MODE_HIGH)) begin
        state_next.port1ModeHigh = sfrReq.wdata;       // R4
      end
    end
    // Register reads, unmapped read zero
    if (sfrReq.read) begin
      state_next.rvalid = 1'b1;
      case (sfrReq.addr)
        ppd_pkg::ADDR_PORT0_MODE_LOW:  state_next.rdata = state_reg.port0ModeLow;
        ppd_pkg::ADDR_PORT0_MODE_HIGH: state_next.rdata = state_reg.port0ModeHigh;
        ppd_pkg::ADDR_PORT1_MODE_LOW:  state_next.rdata = state_reg.port1ModeLow;
        ppd_pkg::ADDR_PORT1_MODE_HIGH: state_next.rdata = state_reg.port1ModeHigh;
        default:                       state_next.rdata = 8'h_00;
      endcase
    end
    // Pin level always sampled, whatever the mode
    state_next.p0Level = p0Sync;                       // R10
    state_next.p1Level = p1Sync;                       // R10
    // External bus ownership of the first port
    state_next.extBusSel = ~extAccessSync | ~generalPort0Enable;  // R9
    // Pad controls follow mode registers one cycle later, first port only while extBusSel is clear
    state_next.pad1 = pad1Dec;                         // R11
    if (state_reg.extBusSel) begin
      state_next.pad0.dataOut      = port0BusOut;      // R9
      state_next.pad0.outEnable    = {8{port0BusDrive}};
      state_next.pad0.pullUpEnable = 8'h_00;
    end else begin
      state_next.pad0 = pad0Dec;                       // R11
    end
  end

  // ----------------------------------------
  // Registers
  // ----------------------------------------
  always_ff @(posedge clock) begin
    if (reset) begin
      state_reg               <= '0;
      state_reg.port0ModeLow  <= ppd_pkg::RESET_MODE_REG;  // R1
      state_reg.port0ModeHigh <= ppd_pkg::RESET_MODE_REG;  // R2
      state_reg.port1ModeLow  <= ppd_pkg::RESET_MODE_REG;  // R3
      state_reg.port1ModeHigh <= ppd_pkg::RESET_MODE_REG;  // R4
    end else begin
      state_reg <= state_next;
    end
  end

  // ----------------------------------------
  // Outputs straight from flops
  // ----------------------------------------
  assign sfrRdata      = state_reg.rdata;
  assign sfrRvalid     = state_reg.rvalid;
  assign port0PinLevel = state_reg.p0Level;
  assign port1PinLevel = state_reg.p1Level;
  assign port0Pad      = state_reg.pad0;
  assign port1Pad      = state_reg.pad1;

endmodule // ppd_port_config
`default_nettype wire

// >>> verification/ppd_pin_board.sv
`timescale 1ns/1ps
`default_nettype none

// ------------------------------
// Board circuitry at one port
// ------------------------------
module ppd_pin_board (
  input  wire logic              clock,
  input  wire ppd_pkg::ppd_pad_t pad,
  input  wire logic [7:0]        extDrive,
  input  wire logic [7:0]        extLevel,
  output var  logic [7:0]        pinLevel
);
  logic [7:0] floatPattern = 8'h5A; // Undriven lines change every cycle
  always @(posedge clock) floatPattern <= ~floatPattern;
  // Resolve each line from pad, board driver and pull-up
  always_comb begin
    for (int i = 0; i < 8; i++) begin
      if (pad.outEnable[i]) pinLevel[i] = pad.dataOut[i];
      else if (extDrive[i]) pinLevel[i] = extLevel[i];
      else if (pad.pullUpEnable[i]) pinLevel[i] = 1'b1;
      else pinLevel[i] = floatPattern[i];
    end
  end
endmodule // ppd_pin_board
`default_nettype wire

// >>> verification/ppd_port_config_bench.sv
`timescale 1ns/1ps
`default_nettype none

module ppd_port_config_bench;
  logic                  clock = 1'b0;
  logic                  reset = 1'b1;
  ppd_pkg::ppd_sfr_req_t sfrReq = '0;
  logic [7:0]            sfrRdata, port0PinLevel, port1PinLevel, port0PinIn, port1PinIn;
  logic                  sfrRvalid;
  logic [7:0]            port0Latch = 8'h00, port1Latch = 8'h00, busOut = 8'h00, extLevel = 8'h00;
  logic                  extPin = 1'b1, gp0Enable = 1'b1, busDrive = 1'b0;
  ppd_pkg::ppd_pad_t     port0Pad, port1Pad, expPad;
  int                    bad_count = 0, tests_run = 0, cycles = 0;

  always #5 clock = ~clock;
  // Hang guard
  always @(posedge clock) begin
    cycles++;
    if (cycles == 2000) begin
      bad_count++;
      stop_test();
    end
  end

  ppd_port_config i_ppd_port_config (.clock(clock), .reset(reset), .sfrReq(sfrReq), .sfrRdata(sfrRdata),
    .sfrRvalid(sfrRvalid), .port0Latch(port0Latch), .port1Latch(port1Latch), .externalAccessPin(extPin),
    .generalPort0Enable(gp0Enable), .port0BusOut(busOut), .port0BusDrive(busDrive), .port0PinIn(port0PinIn),
    .port1PinIn(port1PinIn), .port0PinLevel(port0PinLevel), .port1PinLevel(port1PinLevel),
    .port0Pad(port0Pad), .port1Pad(port1Pad));
  ppd_pin_board i_ppd_pin_board (.clock(clock), .pad(port0Pad), .extDrive(8'hFF), .extLevel(extLevel),
    .pinLevel(port0PinIn));
  ppd_pin_board i_ppd_pin_board_1 (.clock(clock), .pad(port1Pad), .extDrive(8'hFF), .extLevel(extLevel),
    .pinLevel(port1PinIn));

  // Compare tasks
  task automatic check8(input logic [7:0] got, input logic [7:0] exp);
    tests_run++;
    if (got !== exp) begin
      bad_count++;
      $display("[FAIL] %0t got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic check_pad(input ppd_pkg::ppd_pad_t got, input ppd_pkg::ppd_pad_t exp);
    tests_run++;
    if (got !== exp) begin
      bad_count++;
      $display("[FAIL] %0t got %h expected %h", $time, got, exp);
    end
  endtask
  // Register bus cycles, entered at a falling edge
  task automatic sfr_write(input logic [7:0] a, input logic [7:0] d);
    sfrReq <= '{1'b1, 1'b0, a, d};
    @(negedge clock);
    sfrReq.write <= 1'b0;
    @(negedge clock);
  endtask
  task automatic sfr_read(input logic [7:0] a, input logic [7:0] exp);
    sfrReq <= '{1'b0, 1'b1, a, 8'h00};
    @(negedge clock);
    check8({7'h00, sfrRvalid}, 8'h01);
    check8(sfrRdata, exp);
    sfrReq.read <= 1'b0;
    @(negedge clock);
  endtask
  // Expected pads for sixteen mode bits and a latch
  function automatic ppd_pkg::ppd_pad_t exp_pad(input logic [15:0] m, input logic [7:0] l);
    ppd_pkg::ppd_pad_t p;
    for (int i = 0; i < 8; i++) begin
      p.pullUpEnable[i] = !m[2*i+1] && !m[2*i] && l[i];
      p.outEnable[i] = (!m[2*i+1] && (m[2*i] || !l[i])) || (m[2*i+1] && !m[2*i] && !l[i]);
      p.dataOut[i] = !m[2*i+1] && l[i];
    end
    return p;
  endfunction

  // Reset values, readback and an unmapped place
  task automatic reg_access;
    for (int a = 0; a < 4; a++) sfr_read(8'hAC + 8'(a), 8'h00);
    sfr_write(8'hAC, 8'h1B);
    sfr_write(8'hAD, 8'hE4);
    sfr_write(8'hAE, 8'hE4);
    sfr_write(8'hAF, 8'h1B);
    sfr_write(8'hAB, 8'hFF);
    sfr_read(8'hAC, 8'h1B);
    sfr_read(8'hAD, 8'hE4);
    sfr_read(8'hAE, 8'hE4);
    sfr_read(8'hAF, 8'h1B);
    sfr_read(8'hAB, 8'h00);
  endtask
  // Mixed modes on both ports, then sampled pin levels
  task automatic mode_table(input logic [15:0] m, input logic [7:0] l);
    port0Latch <= l;
    port1Latch <= l;
    extLevel <= ~l;
    sfr_write(8'hAC, m[7:0]);
    sfr_write(8'hAD, m[15:8]);
    check_pad(port0Pad, exp_pad(m, l));
    sfr_write(8'hAE, m[7:0]);
    sfr_write(8'hAF, m[15:8]);
    check_pad(port1Pad, exp_pad(m, l));
    repeat (4) @(negedge clock);
    expPad = exp_pad(m, l);
    check8(port1PinLevel, (expPad.outEnable & expPad.dataOut) | (~expPad.outEnable & ~l));
    check8(port0PinLevel, (expPad.outEnable & expPad.dataOut) | (~expPad.outEnable & ~l));
  endtask
  // Memory bus takes the first port, by enable bit and by pin
  task automatic bus_override;
    gp0Enable <= 1'b0;
    busOut <= 8'h69;
    busDrive <= 1'b1;
    repeat (6) @(negedge clock);
    check_pad(port0Pad, '{8'h69, 8'hFF, 8'h00});
    busDrive <= 1'b0;
    repeat (6) @(negedge clock);
    check8(port0Pad.outEnable | port0Pad.pullUpEnable, 8'h00);
    gp0Enable <= 1'b1;
    extPin <= 1'b0;
    busDrive <= 1'b1;
    repeat (6) @(negedge clock);
    check_pad(port0Pad, '{8'h69, 8'hFF, 8'h00});
    extPin <= 1'b1;
    repeat (6) @(negedge clock);
    check_pad(port0Pad, exp_pad(16'h0000, port0Latch));
  endtask

  task automatic stop_test;
    if (bad_count == 0 && tests_run > 0)
      $display("TEST PASSED");
    else
      $display("TEST FAILED");
    $finish;
  endtask

  // Main sequence
  initial begin
    repeat (8) @(negedge clock);
    reset <= 1'b0;
    @(negedge clock);
    reg_access();
    mode_table(16'hE41B, 8'hA5);
    mode_table(16'h1BE4, 8'h5A);
    mode_table(16'hAA55, 8'h3C);
    mode_table(16'hFFFF, 8'hC3);
    mode_table(16'h0000, 8'h96);
    bus_override();
    stop_test();
  end
endmodule // ppd_port_config_bench
`default_nettype wire

// >>> verification/ppd_port_config_properties.sv
`timescale 1ns/1ps
`default_nettype none

// ------------------------------
// Register read, pad control and pin level checks
// ------------------------------
module ppd_port_config_properties (
  input wire logic                  clock,
  input wire logic                  reset,
  input wire ppd_pkg::ppd_sfr_req_t sfrReq,
  input wire logic [7:0]            sfrRdata,
  input wire logic                  sfrRvalid,
  input wire logic [7:0]            port1Latch,
  input wire logic                  generalPort0Enable,
  input wire logic [7:0]            port0BusOut,
  input wire logic                  port0BusDrive,
  input wire logic [7:0]            port1PinIn,
  input wire logic [7:0]            port1PinLevel,
  input wire ppd_pkg::ppd_pad_t     port0Pad,
  input wire ppd_pkg::ppd_pad_t     port1Pad
);
  default clocking @(posedge clock); endclocking
  default disable iff (reset);
  logic [1:0] upCount; // Edges since reset, saturating
  // Count settled edges for the pin pipeline
  always_ff @(posedge clock) begin
    if (reset) upCount <= 2'h0;
    else if (upCount != 2'h3) upCount <= upCount + 2'h1;
  end
  // Mode write of one value to one register
  sequence wr_s(a, d);
    sfrReq.write && sfrReq.addr == a && sfrReq.wdata == d;
  endsequence
  rd_pulse_a: assert property (##1 (sfrRvalid == $past(sfrReq.read)))
    else $error("read answer not one cycle after read");
  rd_unmapped_a: assert property (sfrReq.read && sfrReq.addr[7:2] != 6'h2B |=> sfrRdata == 8'h00)
    else $error("unmapped read not zero");
  pullup_mode_a: assert property (wr_s(8'hAE, 8'h00) |-> ##2 port1Pad.pullUpEnable[3:0] == $past(port1Latch[3:0])
    && port1Pad.outEnable[3:0] == ~$past(port1Latch[3:0])) else $error("pull-up mode pads wrong");
  push_pull_a: assert property (wr_s(8'hAE, 8'h55) |-> ##2 port1Pad.outEnable[3:0] == 4'hF
    && port1Pad.dataOut[3:0] == $past(port1Latch[3:0])) else $error("push-pull pads wrong");
  open_drain_a: assert property (wr_s(8'hAF, 8'hAA) |-> ##2 port1Pad.dataOut[7:4] == 4'h0
    && port1Pad.outEnable[7:4] == ~$past(port1Latch[7:4])) else $error("open-drain pads wrong");
  input_only_a: assert property (wr_s(8'hAF, 8'hFF) |-> ##2
    {port1Pad.dataOut[7:4], port1Pad.outEnable[7:4], port1Pad.pullUpEnable[7:4]} == 12'h000)
    else $error("input mode still drives");
  bus_override_a: assert property ((!generalPort0Enable && $stable(port0BusOut) && $stable(port0BusDrive))[*4]
    |-> port0Pad.outEnable == {8{port0BusDrive}} && port0Pad.pullUpEnable == 8'h00
    && (!port0BusDrive || port0Pad.dataOut == port0BusOut)) else $error("bus override not applied");
  pin_level_a: assert property (upCount == 2'h3 |-> port1PinLevel == $past(port1PinIn, 3))
    else $error("pin level not sampled");
endmodule // ppd_port_config_properties

bind ppd_port_config ppd_port_config_properties i_ppd_port_config_properties (
  .clock(clock), .reset(reset), .sfrReq(sfrReq), .sfrRdata(sfrRdata), .sfrRvalid(sfrRvalid),
  .port1Latch(port1Latch), .generalPort0Enable(generalPort0Enable), .port0BusOut(port0BusOut),
  .port0BusDrive(port0BusDrive), .port1PinIn(port1PinIn), .port1PinLevel(port1PinLevel),
  .port0Pad(port0Pad), .port1Pad(port1Pad));
`default_nettype wire
